/* common/tcr_pkg.sv */
// constants, types and helpers for the thread control record block
package tcr_pkg;

  // ----------------------------------------------------------------
  // record layout, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_EXEC   = 12'h000;
  localparam logic [11:0] OFS_FLAGS  = 12'h008;
  localparam logic [11:0] OFS_STACK  = 12'h010;
  localparam logic [11:0] OFS_INDEX  = 12'h018;
  localparam logic [11:0] OFS_COUNT  = 12'h01C;
  localparam logic [11:0] OFS_ENTRY  = 12'h020;
  localparam logic [11:0] OFS_EXITP  = 12'h028;
  localparam logic [11:0] OFS_FSB    = 12'h030;
  localparam logic [11:0] OFS_GSB    = 12'h038;
  localparam logic [11:0] OFS_FSL    = 12'h040;
  localparam logic [11:0] OFS_GSL    = 12'h044;
  localparam logic [11:0] OFS_FGS    = 12'h048;
  localparam logic [11:0] OFS_PSSP   = 12'h050;

  // ----------------------------------------------------------------
  // operand, command and result registers
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_BASE   = 12'h080;
  localparam logic [11:0] OFS_XPTR   = 12'h088;
  localparam logic [11:0] OFS_SSPIN  = 12'h090;
  localparam logic [11:0] OFS_CFG    = 12'h098;
  localparam logic [11:0] OFS_CMD    = 12'h09C;
  localparam logic [11:0] OFS_TGT    = 12'h0A0;
  localparam logic [11:0] OFS_FSA    = 12'h0A8;
  localparam logic [11:0] OFS_GSA    = 12'h0B0;
  localparam logic [11:0] OFS_FRM    = 12'h0B8;
  localparam logic [11:0] OFS_LIM    = 12'h0C0;
  localparam logic [11:0] OFS_RES    = 12'h0C8;
  localparam logic [11:0] OFS_IST    = 12'h0CC;
  localparam logic [11:0] OFS_IMSK   = 12'h0D0;
  localparam logic [11:0] OFS_SSPO   = 12'h0D8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_DBG     = 0;
  localparam int FLG_NTF     = 1;
  localparam int CFG_DBGATTR = 0;
  localparam int CFG_SS      = 1;
  localparam int CFG_FG      = 2;
  localparam int CFG_M32     = 3;
  localparam int CFG_W       = 4;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_REFUSE  = 1;
  localparam int IRQ_NOTIFY  = 2;
  localparam int IRQ_W       = 3;
  localparam int RES_OK      = 0;
  localparam int RES_STATE   = 1;
  localparam int RES_FRAMES  = 2;
  localparam int RES_INVALID = 3;
  localparam int RES_W       = 4;
  localparam int PAGE_BITS   = 12;
  localparam logic [63:0] RST_64 = 64'h0000_0000_0000_0000;
  localparam logic [31:0] RST_32 = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NONE       = 3'b000,
    OP_ADD        = 3'b001,
    OP_ACCEPT     = 3'b010,
    OP_ENTER      = 3'b011,
    OP_RESUME     = 3'b100,
    OP_ASYNC_EXIT = 3'b101,
    OP_LEAVE      = 3'b110
  } tcr_op_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WR    = 2'b01,
    BUS_RD    = 2'b10,
    BUS_RDONE = 2'b11
  } tcr_bus_t;

  function automatic logic [63:0] wr_half(input logic [63:0] old, input logic hi,
                                          input logic [31:0] d);
    wr_half = hi ? {d, old[31:0]} : {old[63:32], d};
  endfunction

  function automatic logic page_ok(input logic [63:0] v);
    page_ok = (v[PAGE_BITS-1:0] == 12'h000);
  endfunction

endpackage

/* logic/tcr_frame_calc.sv */
// address of the selected state save frame
`timescale 1ns/1ps
module tcr_frame_calc
  import tcr_pkg::*;
#(
  parameter int FRAME_PAGES = 1
) (
  input  logic [63:0] base_in,
  input  logic [63:0] stack_ofs_in,
  input  logic [31:0] index_in,
  output logic [63:0] frame_addr_out
);
  // frames are whole pages, so every frame stays page aligned
  localparam logic [63:0] FRAME_BYTES = 64'(FRAME_PAGES) << PAGE_BITS;

  assign frame_addr_out = base_in + stack_ofs_in + ({32'h0000_0000, index_in} * FRAME_BYTES);

endmodule

/* logic/tcr_record_top.sv */
// thread control record with entry, exit and resume sequencing over ahb-lite
//
// Behaviour
// - execution state reads 0 when free, 1 while a thread executes.
// - offset 16 holds page-aligned frame-stack offset from enclave base.
// - current frame index clears to zero on page add and page accept.
// - offset 28 gives how many save frames this thread owns.
// - entry jumps to enclave base plus entry offset at offset 32.
// - entry stores the asynchronous exit pointer at offset 40.
// - fs and gs bases are enclave base plus page-aligned offsets 48, 56.
// - in 32-bit mode fs and gs limits load from offsets 64, 68.
// - offset 72 is flow-guard save offset, zero when unsupported.
// - offset 80 keeps shadow stack pointer across exits, zero when unsupported.
// - flag bit 0 opts into debug; cleared on add; needs debug attribute.
// - exit notifications only reach threads with flag bit 1 set.
// - current frame index selects save frame inside the frame stack.
// - index increments on asynchronous exit, decrements on resume.
// - entry fails unless a save frame remains available.
// - asynchronous exit saves into the indexed, page-aligned frame.
`timescale 1ns/1ps
module tcr_record_top
  import tcr_pkg::*;
#(
  parameter int FRAME_PAGES = 1
) (
  input  logic        SYS_CLK_IN,
  input  logic        RST_N_IN,
  input  logic        HSEL_IN,
  input  logic [31:0] HADDR_IN,
  input  logic [1:0]  HTRANS_IN,
  input  logic        HWRITE_IN,
  input  logic [2:0]  HSIZE_IN,
  input  logic [31:0] HWDATA_IN,
  input  logic        HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic        HREADYOUT_OUT,
  output logic        HRESP_OUT,
  output logic        IRQ_OUT,
  output logic        ACTIVE_OUT,
  output logic        DEBUG_EN_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tcr_bus_t           state_ff, nxt_state;
  logic [11:0]        addr_ff, nxt_addr;
  logic [31:0]        rdata_ff, nxt_rdata;
  logic               ready_ff, nxt_ready;
  logic               exec_ff, nxt_exec;
  logic [63:0]        flags_ff, nxt_flags;
  logic [63:0]        stk_ff, nxt_stk;
  logic [31:0]        idx_ff, nxt_idx;
  logic [31:0]        cnt_ff, nxt_cnt;
  logic [63:0]        ent_ff, nxt_ent;
  logic [63:0]        exitp_ff, nxt_exitp;
  logic [63:0]        ofs_ff, nxt_ofs;
  logic [63:0]        ogs_ff, nxt_ogs;
  logic [31:0]        fsl_ff, nxt_fsl;
  logic [31:0]        gsl_ff, nxt_gsl;
  logic [63:0]        fgs_ff, nxt_fgs;
  logic [63:0]        pssp_ff, nxt_pssp;
  logic [63:0]        base_ff, nxt_base;
  logic [63:0]        xptr_ff, nxt_xptr;
  logic [63:0]        sspin_ff, nxt_sspin;
  logic [CFG_W-1:0]   cfg_ff, nxt_cfg;
  tcr_op_t            op_ff, nxt_op;
  logic [63:0]        tgt_ff, nxt_tgt;
  logic [63:0]        fsa_ff, nxt_fsa;
  logic [63:0]        gsa_ff, nxt_gsa;
  logic [63:0]        frm_ff, nxt_frm;
  logic [31:0]        fsla_ff, nxt_fsla;
  logic [31:0]        gsla_ff, nxt_gsla;
  logic [63:0]        sspo_ff, nxt_sspo;
  logic [RES_W-1:0]   res_ff, nxt_res;
  logic [IRQ_W-1:0]   ist_ff, nxt_ist;
  logic [IRQ_W-1:0]   msk_ff, nxt_msk;
  logic               irq_ff, nxt_irq;
  logic               dbg_en_ff, nxt_dbg_en;

  logic               take;
  logic               wr_en;
  logic [11:0]        slot;
  logic               hi;
  logic [63:0]        rd_slot;
  logic               rec_bad;
  logic               e_state, e_frames, e_inv;
  logic               op_act, op_ok;
  logic [IRQ_W-1:0]   ev;
  logic [63:0]        entry_sum, fs_sum, gs_sum, frame_sum;

  assign entry_sum = base_ff + ent_ff;
  assign fs_sum    = base_ff + ofs_ff;
  assign gs_sum    = base_ff + ogs_ff;

  tcr_frame_calc #(
    .FRAME_PAGES    (FRAME_PAGES)
  ) u_frame (
    .base_in        (base_ff),
    .stack_ofs_in   (stk_ff),
    .index_in       (idx_ff),
    .frame_addr_out (frame_sum)
  );

  // ----------------------------------------------------------------
  // ahb-lite slave: writes zero-wait, reads one wait state
  // ----------------------------------------------------------------
  // the read wait lets a write in the previous data phase land first
  assign take  = HSEL_IN && HTRANS_IN[1] && HREADY_IN && ready_ff;
  assign wr_en = (state_ff == BUS_WR);
  assign slot  = {addr_ff[11:3], 3'b000};
  assign hi    = addr_ff[2];

  always_comb begin
    rd_slot = RST_64;
    unique case (slot)
      OFS_EXEC:   rd_slot = {63'h0, exec_ff};
      OFS_FLAGS:  rd_slot = flags_ff;
      OFS_STACK:  rd_slot = stk_ff;
      OFS_INDEX:  rd_slot = {cnt_ff, idx_ff};
      OFS_ENTRY:  rd_slot = ent_ff;
      OFS_EXITP:  rd_slot = exitp_ff;
      OFS_FSB:    rd_slot = ofs_ff;
      OFS_GSB:    rd_slot = ogs_ff;
      OFS_FSL:    rd_slot = {gsl_ff, fsl_ff};
      OFS_FGS:    rd_slot = fgs_ff;
      OFS_PSSP:   rd_slot = pssp_ff;
      OFS_BASE:   rd_slot = base_ff;
      OFS_XPTR:   rd_slot = xptr_ff;
      OFS_SSPIN:  rd_slot = sspin_ff;
      OFS_CFG:    rd_slot = {32'h0, 28'h0, cfg_ff};
      OFS_TGT:    rd_slot = tgt_ff;
      OFS_FSA:    rd_slot = fsa_ff;
      OFS_GSA:    rd_slot = gsa_ff;
      OFS_FRM:    rd_slot = frm_ff;
      OFS_LIM:    rd_slot = {gsla_ff, fsla_ff};
      OFS_RES:    rd_slot = {29'h0, ist_ff, 28'h0, res_ff};
      OFS_IMSK:   rd_slot = {32'h0, 29'h0, msk_ff};
      OFS_SSPO:   rd_slot = sspo_ff;
      default:    rd_slot = RST_64;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_ready = ready_ff;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      BUS_RD: begin
        nxt_rdata = hi ? rd_slot[63:32] : rd_slot[31:0];
        nxt_ready = 1'b1;
        nxt_state = BUS_RDONE;
      end
      BUS_IDLE, BUS_WR, BUS_RDONE: begin
        if (take) begin
          nxt_addr  = HADDR_IN[11:0];
          nxt_state = HWRITE_IN ? BUS_WR : BUS_RD;
          nxt_ready = HWRITE_IN;
        end else begin
          nxt_state = BUS_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // operation checks
  // ----------------------------------------------------------------
  // a record that breaks a must-be-zero or alignment field is never run
  assign rec_bad = (|flags_ff[63:2])
                 || (!cfg_ff[CFG_FG] && (fgs_ff != RST_64))
                 || (!cfg_ff[CFG_SS] && (pssp_ff != RST_64))
                 || !page_ok(stk_ff)
                 || !page_ok(ofs_ff) || !page_ok(ogs_ff);

  always_comb begin
    e_state  = 1'b0;
    e_frames = 1'b0;
    e_inv    = 1'b0;
    op_act   = 1'b1;
    unique case (op_ff)
      OP_NONE:   op_act = 1'b0;
      OP_ADD:    e_state = 1'b0;
      OP_ACCEPT: e_state = 1'b0;
      OP_ENTER: begin
        e_state  = exec_ff;
        e_frames = (idx_ff >= cnt_ff);
        e_inv    = rec_bad;
      end
      OP_RESUME: begin
        e_state  = exec_ff;
        e_frames = (idx_ff == RST_32);
        e_inv    = rec_bad;
      end
      OP_ASYNC_EXIT: begin
        e_state  = !exec_ff;
        e_frames = (idx_ff >= cnt_ff);
      end
      OP_LEAVE:  e_state = !exec_ff;
      default:   op_act = 1'b0;
    endcase
  end

  assign op_ok = op_act && !e_state && !e_frames && !e_inv;

  // ----------------------------------------------------------------
  // record fields: software writes, then operation updates win
  // ----------------------------------------------------------------
  always_comb begin
    nxt_exec   = exec_ff;
    nxt_flags  = flags_ff;
    nxt_stk    = stk_ff;
    nxt_idx    = idx_ff;
    nxt_cnt    = cnt_ff;
    nxt_ent    = ent_ff;
    nxt_exitp  = exitp_ff;
    nxt_ofs    = ofs_ff;
    nxt_ogs    = ogs_ff;
    nxt_fsl    = fsl_ff;
    nxt_gsl    = gsl_ff;
    nxt_fgs    = fgs_ff;
    nxt_pssp   = pssp_ff;
    nxt_base   = base_ff;
    nxt_xptr   = xptr_ff;
    nxt_sspin  = sspin_ff;
    nxt_cfg    = cfg_ff;
    nxt_op     = OP_NONE;
    nxt_tgt    = tgt_ff;
    nxt_fsa    = fsa_ff;
    nxt_gsa    = gsa_ff;
    nxt_frm    = frm_ff;
    nxt_fsla   = fsla_ff;
    nxt_gsla   = gsla_ff;
    nxt_sspo   = sspo_ff;
    nxt_res    = res_ff;
    nxt_msk    = msk_ff;
    ev         = '0;
    if (wr_en) begin
      if (slot == OFS_FLAGS) begin
        nxt_flags = wr_half(flags_ff, hi, HWDATA_IN);
        if (!cfg_ff[CFG_DBGATTR]) nxt_flags[FLG_DBG] = flags_ff[FLG_DBG];
      end
      if (slot == OFS_STACK)  nxt_stk    = wr_half(stk_ff, hi, HWDATA_IN);
      if (addr_ff == OFS_INDEX) nxt_idx  = HWDATA_IN;
      if (addr_ff == OFS_COUNT) nxt_cnt  = HWDATA_IN;
      if (slot == OFS_ENTRY)  nxt_ent    = wr_half(ent_ff, hi, HWDATA_IN);
      if (slot == OFS_FSB)    nxt_ofs    = wr_half(ofs_ff, hi, HWDATA_IN);
      if (slot == OFS_GSB)    nxt_ogs    = wr_half(ogs_ff, hi, HWDATA_IN);
      if (addr_ff == OFS_FSL) nxt_fsl    = HWDATA_IN;
      if (addr_ff == OFS_GSL) nxt_gsl    = HWDATA_IN;
      if (slot == OFS_FGS)    nxt_fgs    = wr_half(fgs_ff, hi, HWDATA_IN);
      if (slot == OFS_PSSP)   nxt_pssp   = wr_half(pssp_ff, hi, HWDATA_IN);
      if (slot == OFS_BASE)   nxt_base   = wr_half(base_ff, hi, HWDATA_IN);
      if (slot == OFS_XPTR)   nxt_xptr   = wr_half(xptr_ff, hi, HWDATA_IN);
      if (slot == OFS_SSPIN)  nxt_sspin  = wr_half(sspin_ff, hi, HWDATA_IN);
      if (addr_ff == OFS_CFG) nxt_cfg    = HWDATA_IN[CFG_W-1:0];
      if (addr_ff == OFS_CMD) nxt_op     = tcr_op_t'(HWDATA_IN[2:0]);
      if (addr_ff == OFS_IMSK) nxt_msk   = HWDATA_IN[IRQ_W-1:0];
    end
    if (op_act) begin
      nxt_res = {e_inv, e_frames, e_state, op_ok};
      ev[IRQ_DONE]   = op_ok;
      ev[IRQ_REFUSE] = !op_ok;
    end
    if (op_ok) begin
      unique case (op_ff)
        OP_ADD: begin
          nxt_exec          = 1'b0;
          nxt_idx           = RST_32;
          nxt_flags[FLG_DBG] = 1'b0;
        end
        OP_ACCEPT: nxt_idx = RST_32;
        OP_ENTER: begin
          nxt_exec = 1'b1;
          nxt_exitp = xptr_ff;
          nxt_tgt  = entry_sum;
          nxt_fsa  = fs_sum;
          nxt_gsa  = gs_sum;
          if (cfg_ff[CFG_M32]) begin
            nxt_fsla = fsl_ff;
            nxt_gsla = gsl_ff;
          end
          nxt_sspo = cfg_ff[CFG_SS] ? pssp_ff : RST_64;
        end
        OP_RESUME: begin
          nxt_exec = 1'b1;
          nxt_exitp = xptr_ff;
          nxt_idx  = idx_ff - 32'h0000_0001;
          nxt_fsa  = fs_sum;
          nxt_gsa  = gs_sum;
          nxt_sspo = cfg_ff[CFG_SS] ? pssp_ff : RST_64;
        end
        OP_ASYNC_EXIT: begin
          nxt_exec = 1'b0;
          nxt_frm  = frame_sum;
          nxt_idx  = idx_ff + 32'h0000_0001;
          if (cfg_ff[CFG_SS]) nxt_pssp = sspin_ff;
          ev[IRQ_NOTIFY] = flags_ff[FLG_NTF];
        end
        OP_LEAVE: begin
          nxt_exec = 1'b0;
          if (cfg_ff[CFG_SS]) nxt_pssp = sspin_ff;
        end
        default: nxt_exec = exec_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt status: write one to clear, a new event wins
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ist = ist_ff;
    if (wr_en && (addr_ff == OFS_IST)) nxt_ist = ist_ff & ~HWDATA_IN[IRQ_W-1:0];
    nxt_ist    = nxt_ist | ev;
    nxt_irq    = |(nxt_ist & nxt_msk);
    nxt_dbg_en = nxt_exec && nxt_flags[FLG_DBG];
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_ff  <= BUS_IDLE;
      addr_ff   <= 12'h000;
      rdata_ff  <= RST_32;
      ready_ff  <= 1'b1;
      exec_ff   <= 1'b0;
      flags_ff  <= RST_64;
      stk_ff    <= RST_64;
      idx_ff    <= RST_32;
      cnt_ff    <= RST_32;
      ent_ff    <= RST_64;
      exitp_ff  <= RST_64;
      ofs_ff    <= RST_64;
      ogs_ff    <= RST_64;
      fsl_ff    <= RST_32;
      gsl_ff    <= RST_32;
      fgs_ff    <= RST_64;
      pssp_ff   <= RST_64;
      base_ff   <= RST_64;
      xptr_ff   <= RST_64;
      sspin_ff  <= RST_64;
      cfg_ff    <= '0;
      op_ff     <= OP_NONE;
      tgt_ff    <= RST_64;
      fsa_ff    <= RST_64;
      gsa_ff    <= RST_64;
      frm_ff    <= RST_64;
      fsla_ff   <= RST_32;
      gsla_ff   <= RST_32;
      sspo_ff   <= RST_64;
      res_ff    <= '0;
      ist_ff    <= '0;
      msk_ff    <= '0;
      irq_ff    <= 1'b0;
      dbg_en_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      addr_ff   <= nxt_addr;
      rdata_ff  <= nxt_rdata;
      ready_ff  <= nxt_ready;
      exec_ff   <= nxt_exec;
      flags_ff  <= nxt_flags;
      stk_ff    <= nxt_stk;
      idx_ff    <= nxt_idx;
      cnt_ff    <= nxt_cnt;
      ent_ff    <= nxt_ent;
      exitp_ff  <= nxt_exitp;
      ofs_ff    <= nxt_ofs;
      ogs_ff    <= nxt_ogs;
      fsl_ff    <= nxt_fsl;
      gsl_ff    <= nxt_gsl;
      fgs_ff    <= nxt_fgs;
      pssp_ff   <= nxt_pssp;
      base_ff   <= nxt_base;
      xptr_ff   <= nxt_xptr;
      sspin_ff  <= nxt_sspin;
      cfg_ff    <= nxt_cfg;
      op_ff     <= nxt_op;
      tgt_ff    <= nxt_tgt;
      fsa_ff    <= nxt_fsa;
      gsa_ff    <= nxt_gsa;
      frm_ff    <= nxt_frm;
      fsla_ff   <= nxt_fsla;
      gsla_ff   <= nxt_gsla;
      sspo_ff   <= nxt_sspo;
      res_ff    <= nxt_res;
      ist_ff    <= nxt_ist;
      msk_ff    <= nxt_msk;
      irq_ff    <= nxt_irq;
      dbg_en_ff <= nxt_dbg_en;
    end
  end

  assign HRDATA_OUT    = rdata_ff;
  assign HREADYOUT_OUT = ready_ff;
  assign HRESP_OUT     = 1'b0;
  assign IRQ_OUT       = irq_ff;
  assign ACTIVE_OUT    = exec_ff;
  assign DEBUG_EN_OUT  = dbg_en_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence rd_wait_s;
    !HREADYOUT_OUT ##1 HREADYOUT_OUT;
  endsequence
  sequence enter_ok_s;
    (op_ff == OP_ENTER) && op_ok;
  endsequence
  sequence async_exit_ok_s;
    (op_ff == OP_ASYNC_EXIT) && op_ok;
  endsequence

  read_answer_a: assert property (take && !HWRITE_IN |=> rd_wait_s)
    else $error("read answer not after one wait state");
  add_clears_a: assert property (
    (op_ff == OP_ADD) && op_ok |=> (idx_ff == RST_32) && !flags_ff[FLG_DBG])
    else $error("page add did not clear index and debug flag");
  accept_clears_a: assert property ((op_ff == OP_ACCEPT) && op_ok |=> idx_ff == RST_32)
    else $error("page accept did not clear index");
  enter_busy_a: assert property (
    (op_ff == OP_ENTER) && exec_ff |=> ACTIVE_OUT && ist_ff[IRQ_REFUSE] && res_ff[RES_STATE])
    else $error("entry on busy record not refused");
  enter_frames_a: assert property (
    (op_ff == OP_ENTER) && (idx_ff >= cnt_ff) |=> res_ff[RES_FRAMES] && !res_ff[RES_OK])
    else $error("entry without free frame not refused");
  enter_target_a: assert property (
    enter_ok_s |=> ACTIVE_OUT && (tgt_ff == $past(entry_sum)))
    else $error("entry target wrong");
  exit_ptr_a: assert property (enter_ok_s |=> exitp_ff == $past(xptr_ff))
    else $error("exit pointer not stored on entry");
  seg_base_a: assert property (
    enter_ok_s |=> (fsa_ff == $past(fs_sum)) && (gsa_ff == $past(gs_sum)))
    else $error("segment base wrong");
  exit_step_a: assert property (
    async_exit_ok_s |=> (idx_ff == $past(idx_ff) + 32'h0000_0001)
    && (frm_ff == $past(frame_sum)) && !ACTIVE_OUT)
    else $error("exit frame or index wrong");
  resume_dec_a: assert property (
    (op_ff == OP_RESUME) && op_ok |=> idx_ff == $past(idx_ff) - 32'h0000_0001)
    else $error("resume did not decrement index");
  notify_gate_a: assert property (
    (async_exit_ok_s and (!flags_ff[FLG_NTF] && !ist_ff[IRQ_NOTIFY]))
    |=> !ist_ff[IRQ_NOTIFY])
    else $error("notification without opt-in");
  notify_set_a: assert property (
    (async_exit_ok_s and flags_ff[FLG_NTF]) |=> ist_ff[IRQ_NOTIFY])
    else $error("opted-in thread missed notification");
  reserved_bad_a: assert property (
    (op_ff == OP_ENTER) && (|flags_ff[63:2])
    |=> res_ff[RES_INVALID] && !res_ff[RES_OK] && (ACTIVE_OUT == $past(exec_ff)))
    else $error("invalid record entered");
  irq_level_a: assert property (|(ist_ff & msk_ff) |-> ##[0:1] IRQ_OUT)
    else $error("interrupt not raised");

endmodule

/* bench/tcr_record_top_tb_top.sv */
// self-checking bench for the thread control record block
`timescale 1ns/1ps
module tcr_record_top_tb_top
  import tcr_pkg::*;
();
  localparam int FP = 1;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic        active;
  logic        dbg_en;
  logic [31:0] rdat;
  logic [31:0] base;
  logic [31:0] ofs;
  logic [31:0] ent;
  logic [31:0] xp;
  logic [31:0] shadow_stack_pointer;
  logic [31:0] idx;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  int          seed = 32'hf35ae779;

  always #4 clk = ~clk;

  tcr_record_top #(.FRAME_PAGES(FP)) dut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .IRQ_OUT(irq), .ACTIVE_OUT(active), .DEBUG_EN_OUT(dbg_en));

  // ----------------------------------------------------------------
  // bus master and comparison
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, rdat, e);
  endtask

  task automatic op(input tcr_op_t o);
    wr(OFS_CMD, {29'h0, o});
  endtask

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc("exec", OFS_EXEC, 32'h0);
    rc("unmapped", 12'h0E0, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    $display("test reset done");
    base = $random(seed) & 32'hFFFFF000;
    ofs  = $random(seed) & 32'h00FFF000;
    ent  = $random(seed) & 32'h00FFFFFF;
    xp   = $random(seed);
    shadow_stack_pointer  = $random(seed);
    wr(OFS_BASE, base);
    wr(OFS_STACK, ofs);
    wr(OFS_COUNT, 32'h2);
    wr(OFS_ENTRY, ent);
    wr(OFS_XPTR, xp);
    wr(OFS_IMSK, 32'h7);
    op(OP_ADD);
    wr(OFS_FLAGS, 32'h3);
    rc("flags", OFS_FLAGS, 32'h2);
    rc("frame count", OFS_COUNT, 32'h2);
    $display("test setup done");
    idx = 0;
    repeat (2) begin
      op(OP_ENTER);
      rc("enter res", OFS_RES, 32'h1);
      rc("exec", OFS_EXEC, 32'h1);
      chk("active", {31'h0, active}, 32'h1);
      rc("exit ptr", OFS_EXITP, xp);
      rc("target", OFS_TGT, base + ent);
      op(OP_ENTER);
      rc("busy res", OFS_RES, 32'h2);
      wr(OFS_IST, 32'h7);
      op(OP_ASYNC_EXIT);
      rc("frame", OFS_FRM, base + ofs + idx * FP * 4096);
      idx = idx + 1;
      rc("index up", OFS_INDEX, idx);
      rc("exec", OFS_EXEC, 32'h0);
      rc("status", OFS_IST, 32'h5);
      chk("irq", {31'h0, irq}, 32'h1);
    end
    $display("test enter exit done");
    op(OP_ENTER);
    rc("no frame", OFS_RES, 32'h4);
    op(OP_RESUME);
    rc("index down", OFS_INDEX, idx - 1);
    op(OP_ACCEPT);
    rc("accept idx", OFS_INDEX, 32'h0);
    op(OP_LEAVE);
    rc("exec", OFS_EXEC, 32'h0);
    $display("test resume done");
    // debug attribute, shadow stack support and 32-bit mode all on
    wr(OFS_CFG, 32'hB);
    wr(OFS_FLAGS, 32'h1);
    rc("dbg flag", OFS_FLAGS, 32'h1);
    wr(OFS_FSB, ofs);
    wr(OFS_FSL, ent);
    wr(OFS_PSSP, xp);
    wr(OFS_SSPIN, shadow_stack_pointer);
    op(OP_ENTER);
    rc("fs base", OFS_FSA, base + ofs);
    chk("dbg on", {31'h0, dbg_en}, 32'h1);
    rc("fs limit", OFS_LIM, ent);
    rc("ssp out", OFS_SSPO, xp);
    wr(OFS_IST, 32'h7);
    op(OP_ASYNC_EXIT);
    rc("ssp save", OFS_PSSP, shadow_stack_pointer);
    rc("no notify", OFS_IST, 32'h1);
    chk("dbg off", {31'h0, dbg_en}, 32'h0);
    $display("test options done");
    wr(OFS_IST, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    wr(OFS_IMSK, 32'h0);
    wr(OFS_FLAGS + 12'h4, 32'h1);
    op(OP_ENTER);
    rc("invalid", OFS_RES, 32'h8);
    chk("irq masked", {31'h0, irq}, 32'h0);
    $display("test invalid done");
    end_of_test();
  end
endmodule
